// ### rtl/dmsso_regs.vh
// constants for the data-memory set / skip execution block
// assumes inclusion by the execution unit file only; definitions only
`ifndef DMSSO_REGS_VH
`define DMSSO_REGS_VH
`define DMSSO_OP_NONE 3'h0
`define DMSSO_OP_SET_BYTE 3'h1
`define DMSSO_OP_SET_BIT 3'h2
`define DMSSO_OP_INC_MEM_SKIP 3'h3
`define DMSSO_OP_INC_ACCUM_SKIP 3'h4
`define DMSSO_OP_SKIP_BIT_NZ 3'h5
`define DMSSO_ALL_ONES 8'hFF
`define DMSSO_ONE 8'h01
`define DMSSO_ZERO 8'h00
`define DMSSO_ACCUM_RESET 8'h00
`define DMSSO_SKIP_CYCLES 2'h3
`define DMSSO_PLAIN_CYCLES 2'h2
`endif

// ### rtl/dmsso_data_mem.v
// small data memory, 256 bytes, registered read data
// assumes single clock; one read and one write port
`timescale 1ns/1ps
module dmsso_data_mem (
   input wire clk,
   input wire [7:0] rdAddr,
   output reg [7:0] rdData,
   input wire wrEn,
   input wire [7:0] wrAddr,
   input wire [7:0] wrData
);
   reg [7:0] memArray [0:255];
   always @(posedge clk) begin
      if (wrEn) begin
         memArray[wrAddr] <= wrData;
      end
      rdData <= memArray[rdAddr];
   end
endmodule

// ### rtl/dmsso_exec.v
// execution unit for set, bit-set, increment-skip and bit-test-skip ops
// assumes the decoder holds opCode/memAddr/bitSel with start; memory not reset
`timescale 1ns/1ps
`include "dmsso_regs.vh"
// Function
// - whole-byte set writes all ones to the addressed byte
// - bit set forces chosen bit to one, others kept
// - increment byte, write back, skip next when sum is zero
// - taken skip adds a dummy cycle, three cycles total
// - accumulator variant puts sum in accumulator, memory untouched, skip on zero
// - non-zero result means no skip, next instruction runs
// - none of these operations touch status flags
// - bit test skips when chosen bit is set, memory unchanged
module dmsso_exec (
   input wire clk,
   input wire srst,
   input wire start,
   input wire [2:0] opCode,
   input wire [7:0] memAddr,
   input wire [2:0] bitSel,
   input wire [7:0] dbgAddr,
   output wire [7:0] dbgData,
   output wire busy,
   output wire done,
   output reg skipTaken,
   output reg discardNext,
   output reg [1:0] cycleCount,
   output reg [7:0] accumulator,
   output reg accumulatorWrite
);
   // binary state codes; only a taken skip visits the dummy state
   localparam [1:0] ST_IDLE = 2'h0;
   localparam [1:0] ST_READ = 2'h1;
   localparam [1:0] ST_WRITE = 2'h2;
   localparam [1:0] ST_DUMMY = 2'h3;

   // control registers and their next values
   reg [1:0] state_reg;
   reg [1:0] state_next;
   reg [2:0] op_reg;
   reg [2:0] op_next;
   reg [7:0] addr_reg;
   reg [7:0] addr_next;
   reg [2:0] bit_reg;
   reg [2:0] bit_next;
   // next values of the registered outputs
   reg [7:0] accumulator_next;
   reg accumulatorWrite_next;
   reg skipTaken_next;
   reg discardNext_next;
   reg [1:0] cycleCount_next;
   // execute-stage signals
   reg wrEn;
   reg [7:0] wrData;
   reg skipNow;
   wire [7:0] rdData;
   wire [7:0] incSum;
   wire sumZero;
   wire [7:0] bitMask;
   wire bitHit;
   wire [7:0] rdAddr;
   wire accept;
   genvar g;

   // only idle takes a request; a start while busy or with no op is dropped
   assign accept = (state_reg == ST_IDLE) && start && (opCode != `DMSSO_OP_NONE);
   // the read port doubles as a debug peek while idle and not starting
   assign rdAddr = (state_reg == ST_IDLE) ? (start ? memAddr : dbgAddr) : addr_reg;
   assign dbgData = rdData;
   // eight-bit wrap: all ones plus one gives zero, which is the skip case
   assign incSum = rdData + `DMSSO_ONE;
   assign sumZero = (incSum == `DMSSO_ZERO);
   assign bitHit = |(rdData & bitMask);
   assign busy = (state_reg != ST_IDLE);
   assign done = ((state_reg == ST_WRITE) && !skipNow) || (state_reg == ST_DUMMY);

   // one-hot mask, one compare per bit position
   // a compare per bit keeps a variable shifter out of the data path
   generate
      for (g = 0; g < 8; g = g + 1) begin : gen_mask
         assign bitMask[g] = ({29'h0, bit_reg} == g);
      end
   endgenerate

   // write address comes from the latched address, never from the live port
   dmsso_data_mem u_mem (
      .clk(clk),
      .rdAddr(rdAddr),
      .rdData(rdData),
      .wrEn(wrEn),
      .wrAddr(addr_reg),
      .wrData(wrData)
   );

   // execute stage: memory data is valid while in the write state
   always @* begin
      wrEn = 1'h0;
      wrData = rdData;
      skipNow = 1'h0;
      if (state_reg == ST_WRITE) begin
         case (op_reg)
            `DMSSO_OP_SET_BYTE: begin
               wrEn = 1'h1;
               wrData = `DMSSO_ALL_ONES;
            end
            `DMSSO_OP_SET_BIT: begin
               wrEn = 1'h1;
               wrData = rdData | bitMask;
            end
            `DMSSO_OP_INC_MEM_SKIP: begin
               wrEn = 1'h1;
               wrData = incSum;
               skipNow = sumZero;
            end
            `DMSSO_OP_INC_ACCUM_SKIP: begin
               // memory stays as it was; only the accumulator takes the sum
               wrEn = 1'h0;
               skipNow = sumZero;
            end
            `DMSSO_OP_SKIP_BIT_NZ: begin
               wrEn = 1'h0;
               skipNow = bitHit;
            end
            default: begin
               skipNow = 1'h0;
            end
         endcase
      end
   end

   // sequencer; the dummy state fills the slot of the discarded instruction
   always @* begin
      state_next = state_reg;
      case (state_reg)
         ST_IDLE: begin
            if (accept) begin
               state_next = ST_READ;
            end
         end
         ST_READ: begin
            state_next = ST_WRITE;
         end
         ST_WRITE: begin
            state_next = skipNow ? ST_DUMMY : ST_IDLE;
         end
         ST_DUMMY: begin
            // next fetch overlaps this cycle; its result is thrown away
            state_next = ST_IDLE;
         end
         default: begin
            state_next = ST_IDLE;
         end
      endcase
   end

   // operand capture, only when a request is really taken
   always @* begin
      op_next = op_reg;
      addr_next = addr_reg;
      bit_next = bit_reg;
      if (accept) begin
         op_next = opCode;
         addr_next = memAddr;
         bit_next = bitSel;
      end
   end

   // result side; pulses last one cycle, the count holds until the next op
   always @* begin
      accumulator_next = accumulator;
      accumulatorWrite_next = 1'h0;
      skipTaken_next = 1'h0;
      discardNext_next = 1'h0;
      cycleCount_next = cycleCount;
      if (state_reg == ST_WRITE) begin
         if (op_reg == `DMSSO_OP_INC_ACCUM_SKIP) begin
            accumulator_next = incSum;
            accumulatorWrite_next = 1'h1;
         end
         if (skipNow) begin
            skipTaken_next = 1'h1;
            discardNext_next = 1'h1;
         end else begin
            cycleCount_next = `DMSSO_PLAIN_CYCLES;
         end
      end
      if (state_reg == ST_DUMMY) begin
         cycleCount_next = `DMSSO_SKIP_CYCLES;
      end
   end

   // control state; memory contents are deliberately left out of reset
   always @(posedge clk) begin
      if (srst) begin
         state_reg <= ST_IDLE;
         op_reg <= `DMSSO_OP_NONE;
         addr_reg <= 8'h00;
         bit_reg <= 3'h0;
      end else begin
         state_reg <= state_next;
         op_reg <= op_next;
         addr_reg <= addr_next;
         bit_reg <= bit_next;
      end
   end

   // no status flag register lives here, so none can change
   always @(posedge clk) begin
      if (srst) begin
         accumulator <= `DMSSO_ACCUM_RESET;
         accumulatorWrite <= 1'h0;
         skipTaken <= 1'h0;
         discardNext <= 1'h0;
         cycleCount <= 2'h0;
      end else begin
         accumulator <= accumulator_next;
         accumulatorWrite <= accumulatorWrite_next;
         skipTaken <= skipTaken_next;
         discardNext <= discardNext_next;
         cycleCount <= cycleCount_next;
      end
   end
endmodule

// ### tb/dmsso_exec_assertions.sv
// timing and skip checks on the execution block
// assumes a bind into dmsso_exec
`timescale 1ns/1ps
module dmsso_exec_assertions (
   input wire clk,
   input wire srst,
   input wire start,
   input wire [2:0] opCode,
   input wire busy,
   input wire done,
   input wire skipTaken,
   input wire discardNext,
   input wire [1:0] cycleCount,
   input wire accumulatorWrite
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (srst);
   wire req = start && !busy && opCode != 3'h0;
   a_busy_follows: assert property (req |=> busy)
      else $error("no busy");
   a_done_window: assert property (req |-> ##[2:3] done)
      else $error("done late");
   a_set_noskip: assert property (req && opCode < 3'h3 |-> ##3 !skipTaken)
      else $error("set skipped");
   a_accum_untouched: assert property (req && opCode != 3'h4 |=> !accumulatorWrite [*4])
      else $error("accumulator written");
   a_none_refused: assert property (start && !busy && opCode == 3'h0 |=> !busy)
      else $error("empty op taken");
   a_skip_pair: assert property (skipTaken == discardNext)
      else $error("discard");
   a_skip_done: assert property (skipTaken |-> done)
      else $error("skip not last");
   a_skip_count: assert property (skipTaken |=> cycleCount == 2'h3)
      else $error("count");
   a_done_idle: assert property (done |=> !busy)
      else $error("busy after done");
   c_skip: cover property (skipTaken);
   c_accum_write: cover property (accumulatorWrite);
   c_back: cover property (done ##1 req);
endmodule
bind dmsso_exec dmsso_exec_assertions chk_i (.clk(clk), .srst(srst), .start(start),
   .opCode(opCode), .busy(busy), .done(done), .skipTaken(skipTaken),
   .discardNext(discardNext), .cycleCount(cycleCount), .accumulatorWrite(accumulatorWrite));

// ### tb/data_memory_set_skip_ops_test.sv
// bench with a reference model of the set and skip ops
// assumes the block alone on a 40 MHz clock
`timescale 1ns/1ps
module data_memory_set_skip_ops_test;
   reg clk = 0, srst = 1, start = 0;
   reg [2:0] opCode = 0, bitSel = 0;
   reg [7:0] memAddr = 0, dbgAddr = 0;
   wire [7:0] dbgData, accumulator;
   wire [1:0] cycleCount;
   wire busy, done, skipTaken, discardNext, accumulatorWrite;
   int errors = 0, total_checks = 0, n, mem[4], accModel = 0, aw, e, i;
   logic sk, dn, ws;
   always #12.5 clk = ~clk;
   dmsso_exec dut (.clk(clk), .srst(srst), .start(start), .opCode(opCode),
      .memAddr(memAddr), .bitSel(bitSel), .dbgAddr(dbgAddr), .dbgData(dbgData),
      .busy(busy), .done(done), .skipTaken(skipTaken), .discardNext(discardNext),
      .cycleCount(cycleCount), .accumulator(accumulator), .accumulatorWrite(accumulatorWrite));
   task chk(input string nm, input [7:0] s, input [7:0] x);
      total_checks++;
      if (s !== x) begin
         errors++;
         $display("[ERR] %s exp %h got %h", nm, x, s);
      end
   endtask
   task print_verdict;
      $display("checks %0d errors %0d", total_checks, errors);
      if (errors == 0 && total_checks > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask
   task run(input [2:0] op, input [1:0] a, input [2:0] b);
      @(negedge clk);
      start = 1;
      opCode = op;
      memAddr = {6'h0, a};
      bitSel = b;
      aw = (op == 4);
      case (op)
         1: mem[a] = 255;
         2: mem[a] |= 1 << b;
         3: mem[a] = (mem[a] + 1) % 256;
         4: accModel = (mem[a] + 1) % 256;
      endcase
      e = (op == 3 && mem[a] == 0) || (op == 4 && accModel == 0) || (op == 5 && mem[a][b]);
      @(negedge clk);
      start = 0;
      chk("busy", busy, 1);
      n = 1;
      while (done !== 1'b1 && n < 9) begin
         @(negedge clk);
         n++;
      end
      sk = skipTaken;
      dn = discardNext;
      ws = accumulatorWrite;
      @(negedge clk);
      sk |= skipTaken;
      dn |= discardNext;
      ws |= accumulatorWrite;
      chk("cycles", n, e ? 3 : 2);
      chk("skip", sk, e);
      chk("discard", dn, e);
      chk("count", cycleCount, e ? 3 : 2);
      chk("accumulator write", ws, aw);
      chk("accumulator", accumulator, accModel);
      dbgAddr = memAddr;
      @(negedge clk);
      @(negedge clk);
      chk("mem", dbgData, mem[a]);
   endtask
   initial begin
      void'($urandom(64116));
      repeat (4) @(negedge clk);
      srst = 0;
      for (i = 0; i < 4; i++) run(1, i, 0);
      run(3, 0, 0);
      run(4, 0, 0);
      run(4, 1, 0);
      run(5, 1, 3);
      run(5, 0, 2);
      run(2, 0, 2);
      run(3, 0, 0);
      @(negedge clk);
      start = 1;
      opCode = 0;
      @(negedge clk);
      start = 0;
      chk("none refused", busy, 0);
      for (i = 0; i < 60; i++) run($urandom % 5 + 1, $urandom, $urandom);
      print_verdict;
   end
   initial begin
      #40000;
      errors++;
      print_verdict;
   end
endmodule
